// *** tsp_dev_port.sv ***
// Notes on behaviour
// [RQ1] power-up leaves continuous conversion selected
// [RQ2] reads before first conversion are meaningless
// [RQ3] power-up reset restores all default state
// [RQ4] slave only: shift out on fall, in on rise
// [RQ5] host frames each transfer with select low
// [RQ6] host keeps select high one clock minimum
// [RQ7] read is 16 clocks, read-write 32
// [RQ8] data pin released while select high
// [RQ9] host never drops select on rising clock
// [RQ10] first bit driven at select fall
// [RQ11] host may end read early
// [RQ12] no abort; output refreshed after select rises
// [RQ13] input phase follows 16 clocks, lasts 16
// [RQ14] last eight input bits form the command
// [RQ15] all ones command selects shutdown
// [RQ16] all zeros command selects continuous conversion
// [RQ17] host sends only all ones or zeros
// [RQ18] host may chain id read in one frame
// [RQ19] after resume, temperature only after conversion
// [RQ20] shutdown reads return identification word
// [RQ21] word is 14-bit temperature then two ones
// [RQ22] read anytime; conversion restarts when read ends
// [RQ23] no conversions started while in shutdown
//
// Local design decisions: the address map and register access over Avalon-MM.
`default_nettype none
`include "tsp_consts.svh"

module tsp_dev_port #(
    parameter int unsigned CONV_CYCLES = `TSP_CONV_CYC
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    tsp_link_if.dev link,
    input wire tsp_pkg::tsp_temp_t temp_sample_in,
    output logic shutdown_out,
    output logic data_valid_out
);
    import tsp_pkg::*;

    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_p;
        logic sck_s1;
        logic sck_s2;
        logic sck_p;
        logic sio_s1;
        logic sio_s2;
        logic ph_in;
        logic [`TSP_BITCNT_W-1:0] rcnt;
        tsp_word_t sh;
        logic sio_o;
        logic sio_oe;
        tsp_cmd_t cmd;
        logic shut;
        logic show_id;
        logic valid;
        logic conv_run;
        tsp_temp_t result;
        logic [`TSP_CONV_CNT_W-1:0] conv_cnt;
    } tsp_dev_st_t;

    localparam logic [`TSP_CONV_CNT_W-1:0] CONV_LAST =
        `TSP_CONV_CNT_W'(CONV_CYCLES - 1);

    tsp_dev_st_t q_q;
    tsp_dev_st_t q_d;
    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    logic dec_now;
    logic reload;
    logic [1:0] dec_kind;

    // word presented at the start of an output phase
    function automatic tsp_word_t word_sel(
        input logic id,
        input tsp_temp_t t
    );
        if (id) begin
            word_sel = `TSP_ID_WORD;
        end else begin
            word_sel = {t, `TSP_TAIL_BITS}; // [RQ21]
        end
    endfunction

    // {shutdown, continuous}; any other code leaves the mode alone
    function automatic logic [1:0] cmd_decode(input tsp_cmd_t c);
        cmd_decode = {c == `TSP_CMD_SHUTDOWN, c == `TSP_CMD_CONVERT};
    endfunction

    always_comb begin
        q_d = q_q;
        dec_now = 1'b0;
        reload = 1'b0;
        dec_kind = 2'b00;

        // pin synchronisers
        q_d.cs_s1 = link.cs_n;
        q_d.cs_s2 = q_q.cs_s1;
        q_d.cs_p = q_q.cs_s2;
        q_d.sck_s1 = link.sck;
        q_d.sck_s2 = q_q.sck_s1;
        q_d.sck_p = q_q.sck_s2;
        q_d.sio_s1 = link.sio;
        q_d.sio_s2 = q_q.sio_s1;

        cs_fall = q_q.cs_p & ~q_q.cs_s2;
        cs_rise = ~q_q.cs_p & q_q.cs_s2;
        sck_rise = ~q_q.cs_s2 & ~q_q.sck_p & q_q.sck_s2;
        sck_fall = ~q_q.cs_s2 & q_q.sck_p & ~q_q.sck_s2;

        // conversion timer stands in for the converter
        if (q_q.conv_run) begin
            if (q_q.conv_cnt == CONV_LAST) begin
                q_d.result = temp_sample_in; // [RQ22]
                q_d.valid = 1'b1; // [RQ2]
                q_d.show_id = 1'b0; // [RQ19]
                q_d.conv_cnt = '0;
                // inside a frame the next start waits for select high
                q_d.conv_run = q_q.cs_s2; // [RQ22]
            end else begin
                q_d.conv_cnt = q_q.conv_cnt + 1'b1;
            end
        end

        if (cs_fall) begin
            // first bit goes out at once, rest on falling edges
            q_d.ph_in = 1'b0;
            q_d.rcnt = '0;
            q_d.sh = word_sel(q_q.shut | q_q.show_id, q_q.result); // [RQ12]
            q_d.sio_o = q_d.sh[`TSP_WORD_W-1]; // [RQ10]
            q_d.sh = {q_d.sh[`TSP_WORD_W-2:0], 1'b0};
            q_d.sio_oe = 1'b1; // [RQ10]
        end else if (cs_rise) begin
            q_d.sio_oe = 1'b0; // [RQ8]
            // early end of a read needs no cleanup
            if (q_q.ph_in && q_q.rcnt >= `TSP_CMD_MIN_BITS) begin
                dec_now = 1'b1; // [RQ14]
            end
        end else if (sck_rise) begin
            if (q_q.ph_in) begin
                q_d.cmd = {q_q.cmd[`TSP_CMD_W-2:0], q_q.sio_s2}; // [RQ4]
            end
            q_d.rcnt = q_q.rcnt + 1'b1;
            if (q_q.rcnt == `TSP_PHASE_LAST) begin
                q_d.ph_in = ~q_q.ph_in; // [RQ13] [RQ7]
                if (q_q.ph_in) begin
                    // full input phase: act on it, then output again
                    dec_now = 1'b1; // [RQ14]
                    reload = 1'b1;
                end else begin
                    q_d.sio_oe = 1'b0; // [RQ13]
                end
            end
        end else if (sck_fall && !q_q.ph_in) begin
            q_d.sio_o = q_q.sh[`TSP_WORD_W-1]; // [RQ4]
            q_d.sh = {q_q.sh[`TSP_WORD_W-2:0], 1'b0};
            q_d.sio_oe = 1'b1;
        end

        if (dec_now) begin
            dec_kind = cmd_decode(q_d.cmd);
            if (dec_kind[1]) begin
                q_d.shut = 1'b1; // [RQ15]
                q_d.conv_run = 1'b0; // [RQ23]
                q_d.conv_cnt = '0;
            end else if (dec_kind[0] && q_q.shut) begin
                q_d.shut = 1'b0; // [RQ16]
                q_d.show_id = 1'b1; // [RQ19]
                q_d.conv_run = 1'b1;
                q_d.conv_cnt = '0;
            end
        end

        if (reload) begin
            q_d.sh = word_sel(q_d.shut | q_d.show_id, q_d.result); // [RQ20]
        end

        // a finished read outside shutdown starts the next conversion only if the timer is stopped
        if (cs_rise && !q_d.shut && !q_d.conv_run) begin
            q_d.conv_run = 1'b1; // [RQ22] [RQ23]
            q_d.conv_cnt = '0;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            q_q <= '0; // [RQ3]
            q_q.cs_s1 <= 1'b1;
            q_q.cs_s2 <= 1'b1;
            q_q.cs_p <= 1'b1;
            q_q.conv_run <= 1'b1; // [RQ1]
        end else begin
            q_q <= q_d;
        end
    end

    assign link.dev_sio_o = q_q.sio_o;
    assign link.dev_sio_oe = q_q.sio_oe;
    assign shutdown_out = q_q.shut;
    assign data_valid_out = q_q.valid;
endmodule

`default_nettype wire

// *** tsp_consts.svh ***
`ifndef TSP_CONSTS_SVH
`define TSP_CONSTS_SVH

// serial word and phase layout
`define TSP_WORD_W 16
`define TSP_TEMP_W 14
`define TSP_TAIL_BITS 2'h3
`define TSP_CMD_W 8
`define TSP_CMD_SHUTDOWN 8'hff
`define TSP_CMD_CONVERT 8'h00
`define TSP_CMD_MIN_BITS 4'h8
`define TSP_BITCNT_W 4
`define TSP_PHASE_LAST 4'hf
`define TSP_PHASE_SEL 4
// arbitrary identification word, low two bits stay ones
`define TSP_ID_WORD 16'h5a03

// clock and timing
`define TSP_CLK_MHZ 40
`define TSP_CLK_NS 25
`define TSP_CONV_TIME_MS 228
`define TSP_CONV_CYC (`TSP_CONV_TIME_MS * 1000 * `TSP_CLK_MHZ)
`define TSP_CONV_CNT_W 24
`define TSP_SCK_HALF_NS 80
`define TSP_SCK_HALF_CYC ((`TSP_SCK_HALF_NS + `TSP_CLK_NS - 1) / `TSP_CLK_NS)
`define TSP_CS_GAP_NS 160
`define TSP_CS_GAP_CYC ((`TSP_CS_GAP_NS + `TSP_CLK_NS - 1) / `TSP_CLK_NS)
`define TSP_TMR_W 4

// host register map, word addresses
`define TSP_BUS_W 32
`define TSP_ADDR_W 2
`define TSP_REG_CTRL 2'h0
`define TSP_REG_TX 2'h1
`define TSP_REG_RX 2'h2
`define TSP_CTRL_LEN_W 7
`define TSP_CTRL_START 8
`define TSP_CTRL_BUSY 9
`define TSP_MAX_CLKS 7'h40

`endif

// *** tsp_pkg.sv ***
`default_nettype none
`include "tsp_consts.svh"

package tsp_pkg;
    typedef logic [`TSP_TEMP_W-1:0] tsp_temp_t;
    typedef logic [`TSP_WORD_W-1:0] tsp_word_t;
    typedef logic [`TSP_CMD_W-1:0] tsp_cmd_t;
    typedef logic [`TSP_BUS_W-1:0] tsp_bus_t;
    typedef logic [`TSP_ADDR_W-1:0] tsp_addr_t;
    typedef logic [`TSP_CTRL_LEN_W-1:0] tsp_len_t;
    typedef logic [`TSP_TMR_W-1:0] tsp_tmr_t;
    typedef enum logic [1:0] {
        hs_idle,
        hs_low,
        hs_high,
        hs_gap
    } tsp_host_state_t;
endpackage

`default_nettype wire

// *** tsp_link_if.sv ***
`default_nettype none

interface tsp_link_if;
    logic cs_n;
    logic sck;
    logic dev_sio_o;
    logic dev_sio_oe;
    logic host_sio_o;
    logic host_sio_oe;
    logic sio;

    // resolved data wire; idles high when nobody drives
    assign sio = dev_sio_oe ? dev_sio_o : (host_sio_oe ? host_sio_o : 1'b1);

    modport dev (
        input cs_n,
        input sck,
        input sio,
        output dev_sio_o,
        output dev_sio_oe
    );

    modport host (
        output cs_n,
        output sck,
        output host_sio_o,
        output host_sio_oe,
        input sio
    );
endinterface

`default_nettype wire

// *** tsp_host_ctl.sv ***
`default_nettype none
`include "tsp_consts.svh"

module tsp_host_ctl (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    tsp_link_if.host link,
    input wire tsp_pkg::tsp_addr_t avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire tsp_pkg::tsp_bus_t avs_writedata_in,
    output tsp_pkg::tsp_bus_t avs_readdata_out,
    output logic avs_waitrequest_out
);
    import tsp_pkg::*;

    typedef struct packed {
        tsp_host_state_t st;
        tsp_tmr_t cnt;
        tsp_len_t idx;
        tsp_len_t len;
        tsp_bus_t tx;
        tsp_bus_t rx;
        logic cs_n;
        logic sck;
        logic sio_o;
        logic sio_oe;
        logic sio_s1;
        logic sio_s2;
        logic wreq;
        tsp_bus_t rdata;
    } tsp_host_st_t;

    localparam tsp_tmr_t HALF_LAST = `TSP_TMR_W'(`TSP_SCK_HALF_CYC - 1);
    localparam tsp_tmr_t GAP_LAST = `TSP_TMR_W'(`TSP_CS_GAP_CYC - 1);

    tsp_host_st_t q_q;
    tsp_host_st_t q_d;
    logic acc_wr;
    tsp_len_t nxt;
    tsp_len_t wlen;

    // bits 16..31 and 48..63 of a frame are host-driven
    function automatic logic host_drives(input tsp_len_t i);
        host_drives = i[`TSP_PHASE_SEL];
    endfunction

    always_comb begin
        q_d = q_q;
        q_d.sio_s1 = link.sio;
        q_d.sio_s2 = q_q.sio_s1;
        nxt = q_q.idx + 1'b1;
        wlen = avs_writedata_in[`TSP_CTRL_LEN_W-1:0];

        // one wait cycle per access, then the answer
        q_d.wreq = 1'b1;
        acc_wr = avs_write_in & ~q_q.wreq;
        if ((avs_read_in | avs_write_in) && q_q.wreq) begin
            q_d.wreq = 1'b0;
            q_d.rdata = '0;
            case (avs_address_in)
                `TSP_REG_CTRL: begin
                    q_d.rdata[`TSP_CTRL_LEN_W-1:0] = q_q.len;
                    q_d.rdata[`TSP_CTRL_BUSY] = q_q.st != hs_idle;
                end
                `TSP_REG_TX: q_d.rdata = q_q.tx;
                `TSP_REG_RX: q_d.rdata = q_q.rx;
                default: q_d.rdata = '0;
            endcase
        end

        case (q_q.st)
            hs_idle: begin
                if (acc_wr && avs_address_in == `TSP_REG_TX) begin
                    q_d.tx = avs_writedata_in;
                end
                if (acc_wr && avs_address_in == `TSP_REG_CTRL &&
                    avs_writedata_in[`TSP_CTRL_START] && wlen != '0 &&
                    wlen <= `TSP_MAX_CLKS) begin
                    q_d.len = wlen; // [RQ7] [RQ11] [RQ13]
                    q_d.rx = '0;
                    q_d.idx = '0;
                    q_d.cs_n = 1'b0; // [RQ5] [RQ9]
                    q_d.sck = 1'b0;
                    q_d.cnt = HALF_LAST;
                    q_d.st = hs_low;
                end
            end
            hs_low: begin
                if (q_q.cnt == '0) begin
                    q_d.sck = 1'b1;
                    q_d.cnt = HALF_LAST;
                    q_d.st = hs_high;
                end else begin
                    q_d.cnt = q_q.cnt - 1'b1;
                end
            end
            hs_high: begin
                if (q_q.cnt == '0) begin
                    // sample late in the high half, past sync delay
                    if (!host_drives(q_q.idx)) begin
                        q_d.rx = {q_q.rx[`TSP_BUS_W-2:0], q_q.sio_s2};
                    end
                    q_d.sck = 1'b0;
                    if (nxt == q_q.len) begin
                        q_d.cs_n = 1'b1; // [RQ5]
                        q_d.sio_oe = 1'b0;
                        q_d.cnt = GAP_LAST;
                        q_d.st = hs_gap;
                    end else begin
                        q_d.idx = nxt;
                        q_d.sio_oe = host_drives(nxt); // [RQ13] [RQ18]
                        if (host_drives(nxt)) begin
                            q_d.sio_o = q_q.tx[`TSP_BUS_W-1];
                            q_d.tx = {q_q.tx[`TSP_BUS_W-2:0], 1'b0};
                        end
                        q_d.cnt = HALF_LAST;
                        q_d.st = hs_low;
                    end
                end else begin
                    q_d.cnt = q_q.cnt - 1'b1;
                end
            end
            hs_gap: begin
                if (q_q.cnt == '0) begin
                    q_d.st = hs_idle; // [RQ6]
                end else begin
                    q_d.cnt = q_q.cnt - 1'b1;
                end
            end
            default: q_d.st = hs_idle;
        endcase
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            q_q <= '0;
            q_q.st <= hs_idle;
            q_q.cs_n <= 1'b1;
            q_q.wreq <= 1'b1;
        end else begin
            q_q <= q_d;
        end
    end

    assign link.cs_n = q_q.cs_n;
    assign link.sck = q_q.sck;
    assign link.host_sio_o = q_q.sio_o;
    assign link.host_sio_oe = q_q.sio_oe;
    assign avs_readdata_out = q_q.rdata;
    assign avs_waitrequest_out = q_q.wreq;
endmodule

`default_nettype wire

// *** tsp_link_assertions.sv ***
`default_nettype none

module tsp_link_assertions (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic dev_sio_o,
    input wire logic dev_sio_oe,
    input wire logic host_sio_o,
    input wire logic host_sio_oe
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    sequence s_gap;
        cs_n [*7];
    endsequence
    sequence s_setup;
        !sck [*4];
    endsequence

    property p_gap;
        $rose(cs_n) |-> s_gap;
    endproperty
    property p_release;
        cs_n [*5] |-> !dev_sio_oe;
    endproperty
    property p_first;
        $fell(cs_n) |-> ##[1:4] dev_sio_oe;
    endproperty
    property p_setup;
        $fell(cs_n) |-> s_setup;
    endproperty
    property p_shift_out;
        dev_sio_oe && $past(dev_sio_oe) && $changed(dev_sio_o)
            |-> !sck && !$past(sck);
    endproperty
    property p_hold_in;
        host_sio_oe && $rose(sck) |-> $stable(host_sio_o) [*3];
    endproperty
    property p_idle_clk;
        cs_n |-> !sck;
    endproperty
    property p_no_fight;
        dev_sio_oe |-> !host_sio_oe;
    endproperty

    a_gap: assert property (p_gap)
        else $error("select gap too short");
    a_release: assert property (p_release)
        else $error("data pin driven while deselected");
    a_first: assert property (p_first)
        else $error("first bit not driven after select fall");
    a_setup: assert property (p_setup)
        else $error("clock rose too soon after select fall");
    a_shift_out: assert property (p_shift_out)
        else $error("output bit changed outside clock low");
    a_hold_in: assert property (p_hold_in)
        else $error("input bit moved near rising clock");
    a_idle_clk: assert property (p_idle_clk)
        else $error("serial clock active while deselected");
    a_no_fight: assert property (p_no_fight)
        else $error("both ends drive the data pin");
endmodule

`default_nettype wire

// *** tb.sv ***
`default_nettype none
`include "tsp_consts.svh"

`define CHK(nm, exp, got) begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
        bad_count++; \
        $display("[FAIL] %s exp %h got %h", nm, exp, got); \
    end \
end

module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import tsp_pkg::*;

    logic clk_sys_in, rst_in, avs_read, avs_write, avs_waitrequest;
    logic shutdown, data_valid;
    tsp_addr_t avs_address;
    tsp_bus_t avs_writedata, avs_readdata, rd;
    tsp_temp_t temp_sample;
    int bad_count = 0;
    int cmp_count = 0;
    tsp_temp_t row_t [4] = '{14'h0320, 14'h12c0, 14'h3fff, 14'h3b00};
    tsp_word_t row_w [4] = '{16'h0c83, 16'h4b03, 16'hffff, 16'hec03};

    tsp_link_if tsp_link_if_inst ();
    tsp_dev_port #(.CONV_CYCLES(40)) tsp_dev_port_inst (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .link(tsp_link_if_inst),
        .temp_sample_in(temp_sample),
        .shutdown_out(shutdown),
        .data_valid_out(data_valid)
    );
    tsp_host_ctl tsp_host_ctl_inst (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .link(tsp_link_if_inst),
        .avs_address_in(avs_address),
        .avs_read_in(avs_read),
        .avs_write_in(avs_write),
        .avs_writedata_in(avs_writedata),
        .avs_readdata_out(avs_readdata),
        .avs_waitrequest_out(avs_waitrequest)
    );
    tsp_link_assertions tsp_link_assertions_inst (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .cs_n(tsp_link_if_inst.cs_n),
        .sck(tsp_link_if_inst.sck),
        .dev_sio_o(tsp_link_if_inst.dev_sio_o),
        .dev_sio_oe(tsp_link_if_inst.dev_sio_oe),
        .host_sio_o(tsp_link_if_inst.host_sio_o),
        .host_sio_oe(tsp_link_if_inst.host_sio_oe)
    );

    task automatic summarize;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic bus(input logic wr, input tsp_addr_t a, input tsp_bus_t wd);
        @(posedge clk_sys_in);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk_sys_in);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // one framed transfer: load tx, start, poll busy, fetch rx
    task automatic xfer(input logic [6:0] len, input tsp_bus_t tx);
        bus(1'b1, `TSP_REG_TX, tx);
        bus(1'b1, `TSP_REG_CTRL, {23'h0, 2'h2, len});
        do begin
            bus(1'b0, `TSP_REG_CTRL, '0);
        end while (rd[`TSP_CTRL_BUSY] !== 1'b0);
        `CHK("ctrl len", {25'h0, len}, rd)
        bus(1'b0, `TSP_REG_RX, '0);
    endtask

    task automatic note(input string s);
        $display("test done: %s", s);
    endtask

    initial begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end

    initial begin
        repeat (40000) @(posedge clk_sys_in);
        bad_count++;
        summarize;
    end

    initial begin
        rst_in = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = '0;
        avs_writedata = '0;
        temp_sample = 14'h0320;
        repeat (20) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        xfer(16, '0);
        `CHK("early word", 16'h0003, rd[15:0])
        `CHK("mode", 1'b0, shutdown)
        note("power-up");
        for (int i = 0; i < 4; i++) begin
            temp_sample <= row_t[i];
            repeat (100) @(posedge clk_sys_in);
            xfer(16, '0);
            `CHK("temp word", row_w[i], rd[15:0])
            `CHK("valid", 1'b1, data_valid)
        end
        note("rows");
        xfer(8, '0);
        `CHK("short read", 8'hec, rd[7:0])
        xfer(20, 32'hffff_0000);
        `CHK("few bits", 1'b0, shutdown)
        xfer(32, 32'hff5a_0000);
        `CHK("odd code", 1'b0, shutdown)
        `CHK("rw word", 16'hec03, rd[15:0])
        xfer(32, 32'h00ff_0000);
        `CHK("mode", 1'b1, shutdown)
        xfer(16, '0);
        `CHK("id", `TSP_ID_WORD, rd[15:0])
        repeat (100) @(posedge clk_sys_in);
        xfer(16, '0);
        `CHK("id idle", `TSP_ID_WORD, rd[15:0])
        `CHK("no conv", 1'b0, tsp_dev_port_inst.q_q.conv_run)
        xfer(32, 32'hff00_0000);
        `CHK("mode", 1'b0, shutdown)
        xfer(16, '0);
        `CHK("resume", `TSP_ID_WORD, rd[15:0])
        repeat (100) @(posedge clk_sys_in);
        xfer(16, '0);
        `CHK("resumed", 16'hec03, rd[15:0])
        note("modes");
        xfer(64, 32'hffff_0000);
        `CHK("chain temp", 16'hec03, rd[31:16])
        `CHK("chain id", `TSP_ID_WORD, rd[15:0])
        `CHK("chain mode", 1'b0, shutdown)
        note("chain");
        bus(1'b1, 2'h3, 32'hffff_ffff);
        bus(1'b0, 2'h3, '0);
        `CHK("unmapped", 32'h0, rd)
        note("unmapped");
        xfer(32, 32'h00ff_0000);
        @(posedge clk_sys_in);
        rst_in <= 1'b1;
        repeat (20) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        @(posedge clk_sys_in);
        `CHK("reset mode", 1'b0, shutdown)
        `CHK("reset valid", 1'b0, data_valid)
        xfer(16, '0);
        `CHK("reset word", 16'h0003, rd[15:0])
        note("reset");
        summarize;
    end
endmodule

`default_nettype wire
